/* File: logic/cab_defs.vh */
// Operation codes, flag positions, masks and cycle counts of the execution unit
`ifndef CAB_DEFS_VH
`define CAB_DEFS_VH
`define CAB_OP_ADD 6'h00
`define CAB_OP_ADC 6'h01
`define CAB_OP_WSUM 6'h02
`define CAB_OP_SUB 6'h03
`define CAB_OP_DIFI 6'h04
`define CAB_OP_DIFB 6'h05
`define CAB_OP_DIFIB 6'h06
`define CAB_OP_WDIF 6'h07
`define CAB_OP_AND 6'h08
`define CAB_OP_CONJI 6'h09
`define CAB_OP_OR 6'h0a
`define CAB_OP_UNI 6'h0b
`define CAB_OP_XUNI 6'h0c
`define CAB_OP_INV 6'h0d
`define CAB_OP_AINV 6'h0e
`define CAB_OP_SETM 6'h0f
`define CAB_OP_CLRM 6'h10
`define CAB_OP_INC 6'h11
`define CAB_OP_DEC 6'h12
`define CAB_OP_PROBE 6'h13
`define CAB_OP_ZERO 6'h14
`define CAB_OP_ONES 6'h15
`define CAB_OP_UPROD 6'h16
`define CAB_OP_SPROD 6'h17
`define CAB_OP_MPROD 6'h18
`define CAB_OP_FUPROD 6'h19
`define CAB_OP_FSPROD 6'h1a
`define CAB_OP_FMPROD 6'h1b
`define CAB_OP_RGOTO 6'h1c
`define CAB_OP_PGOTO 6'h1d
`define CAB_OP_AGOTO 6'h1e
`define CAB_OP_RINVOKE 6'h1f
`define CAB_OP_PINVOKE 6'h20
`define CAB_OP_AINVOKE 6'h21
`define CAB_OP_REXIT 6'h22
`define CAB_OP_IEXIT 6'h23
`define CAB_OP_CESKIP 6'h24
`define CAB_OP_DFO 6'h25
`define CAB_OP_DFC 6'h26
`define CAB_OP_DFI 6'h27
`define CAB_OP_SRBL 6'h28
`define CAB_OP_SRBH 6'h29
`define CAB_OP_SIBL 6'h2a
`define CAB_OP_SIBH 6'h2b
`define CAB_OP_BFH 6'h2c
`define CAB_OP_BFL 6'h2d
`define CAB_OP_BEQ 6'h2e
`define CAB_OP_BNE 6'h2f
`define CAB_OP_BCH 6'h30
`define CAB_OP_BCL 6'h31
`define CAB_OP_BUGE 6'h32
`define CAB_OP_BULT 6'h33
`define CAB_OP_BNEG 6'h34
`define CAB_OP_BNNEG 6'h35
`define CAB_OP_BSGE 6'h36
`define CAB_OP_BSLT 6'h37
`define CAB_OP_BHH 6'h38
`define CAB_OP_BHL 6'h39
`define CAB_FC 0
`define CAB_FZ 1
`define CAB_FN 2
`define CAB_FV 3
`define CAB_FS 4
`define CAB_FH 5
`define CAB_FI 7
`define CAB_M_ARITH 8'h2f
`define CAB_M_LOGIC 8'h0e
`define CAB_M_INV 8'h0f
`define CAB_M_WORD 8'h1f
`define CAB_M_MUL 8'h03
`define CAB_M_IRQ 8'h80
`define CAB_FLAGS_RST 8'h00
`define CAB_ALU_ADD 3'h0
`define CAB_ALU_SUB 3'h1
`define CAB_ALU_AND 3'h2
`define CAB_ALU_OR 3'h3
`define CAB_ALU_XOR 3'h4
`define CAB_CYC_1 3'h1
`define CAB_CYC_2 3'h2
`define CAB_CYC_3 3'h3
`define CAB_CYC_4 3'h4
`endif

/* File: logic/cab_alu8.v */
// Eight-bit adder, subtractor and logic unit with carry, half-carry and overflow
`timescale 1ns/1ps
`default_nettype none
`include "cab_defs.vh"
module cab_alu8 (
   // Operands
   input wire [7:0] a_in,
   input wire [7:0] b_in,
   input wire cin_in,
   input wire [2:0] mode_in,
   // Result and flags
   output reg [7:0] res_out,
   output reg c_out,
   output reg h_out,
   output reg v_out
);
   always @* begin
      res_out = 8'h00;
      c_out = 1'b0;
      h_out = 1'b0;
      v_out = 1'b0;
      case (mode_in)
         `CAB_ALU_ADD: begin
            {c_out, res_out} = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin_in};
            h_out = (a_in[3] & b_in[3]) | (b_in[3] & ~res_out[3]) | (~res_out[3] & a_in[3]);
            v_out = (a_in[7] & b_in[7] & ~res_out[7]) | (~a_in[7] & ~b_in[7] & res_out[7]);
         end
         `CAB_ALU_SUB: begin
            res_out = a_in - b_in - {7'h00, cin_in};
            c_out = (~a_in[7] & b_in[7]) | (b_in[7] & res_out[7]) | (res_out[7] & ~a_in[7]);
            h_out = (~a_in[3] & b_in[3]) | (b_in[3] & res_out[3]) | (res_out[3] & ~a_in[3]);
            v_out = (a_in[7] & ~b_in[7] & ~res_out[7]) | (~a_in[7] & b_in[7] & res_out[7]);
         end
         `CAB_ALU_AND: res_out = a_in & b_in;
         `CAB_ALU_OR: res_out = a_in | b_in;
         `CAB_ALU_XOR: res_out = a_in ^ b_in;
         default: res_out = 8'h00;
      endcase
   end
endmodule // cab_alu8
`default_nettype wire

/* File: logic/cab_mul.v */
// Eight by eight multiplier with signed, mixed and fractional forms
`timescale 1ns/1ps
`default_nettype none
module cab_mul (
   // Operands
   input wire [7:0] a_in,
   input wire [7:0] b_in,
   input wire a_signed_in,
   input wire b_signed_in,
   input wire frac_in,
   // Product
   output wire [15:0] prod_out,
   output wire carry_out
);
   wire signed [8:0] a_ext;
   wire signed [8:0] b_ext;
   wire signed [17:0] raw;
   assign a_ext = {a_signed_in & a_in[7], a_in};
   assign b_ext = {b_signed_in & b_in[7], b_in};
   assign raw = a_ext * b_ext;
   // Carry is bit 15 of the unshifted product
   assign carry_out = raw[15];
   assign prod_out = frac_in ? {raw[14:0], 1'b0} : raw[15:0];
endmodule // cab_mul
`default_nettype wire

/* File: logic/cab_exec.v */
// Arithmetic, multiply, jump, call, skip and branch execution unit
// Operation
// - Add and add-with-carry, five flags, one cycle
// - Word immediate sum, five flags, two cycles
// - Subtracts with or without borrow, one cycle
// - Word immediate difference, five flags, two cycles
// - And, or, xor update Z N V only
// - Inversion and arithmetic inverse with their flags
// - Set mask ORs, clear mask ANDs complement
// - Step, probe, zero update Z N V; ones leaves flags
// - Products into pair, Z and C, two cycles
// - Fractional products shifted left one bit
// - Relative, pointer and absolute goto timing
// - Invokes three or four, exits four cycles
// - Skip next instruction when registers equal
// - Compare forms set flags, write nothing
// - Skip on working register bit value
// - Skip on I/O register bit value
// - Branch on selected flag bit, 1/2 cycles
// - Named branches test Z, C, N, H
// - Signed branches test N xor V
`timescale 1ns/1ps
`default_nettype none
`include "cab_defs.vh"
module cab_exec (
   // Clock and reset
   input wire sys_clk_in,
   input wire resetn_in,
   // Instruction request
   input wire start_in,
   input wire [5:0] op_in,
   input wire [7:0] rd_val_in,
   input wire [7:0] rr_val_in,
   input wire [7:0] imm_in,
   input wire [15:0] word_in,
   input wire [2:0] bit_sel_in,
   input wire io_bit_in,
   input wire next_two_word_in,
   // Program counter sources
   input wire [15:0] pc_in,
   input wire [11:0] disp_in,
   input wire [15:0] target_in,
   input wire [15:0] z_ptr_in,
   input wire [15:0] stack_pc_in,
   // Flag register load from the core
   input wire flags_we_in,
   input wire [7:0] flags_wr_in,
   // Status
   output reg busy_out,
   output reg done_out,
   // Register file writes
   output reg rd_we_out,
   output reg [7:0] result_out,
   output reg word_we_out,
   output reg [15:0] word_out,
   output reg prod_we_out,
   output reg [15:0] product_out,
   // Flags
   output reg [7:0] flags_out,
   // Program counter and stack
   output reg pc_we_out,
   output reg [15:0] pc_out,
   output reg push_we_out,
   output reg [15:0] push_addr_out
);
   reg rst_meta;
   reg rst_sync_n;
   reg [2:0] cnt;
   reg [7:0] alu_a;
   reg [7:0] alu_b;
   reg alu_cin;
   reg [2:0] alu_mode;
   wire [7:0] alu_res;
   wire alu_c;
   wire alu_h;
   wire alu_v;
   reg mul_as;
   reg mul_bs;
   reg mul_frac;
   wire [15:0] mul_prod;
   wire mul_c;
   reg [7:0] next_res;
   reg [15:0] next_word;
   reg [15:0] next_pc;
   reg [15:0] next_push;
   reg [2:0] next_cyc;
   reg next_rd_we;
   reg next_word_we;
   reg next_prod_we;
   reg next_push_we;
   reg [7:0] next_mask;
   reg [7:0] next_calc;
   wire [7:0] next_flags;
   reg [7:0] pend_flags;
   reg [3:0] pend_we;
   wire take;
   wire fire;
   wire [3:0] fire_we;
   wire [7:0] fire_flags;
   wire [15:0] pc_inc;
   wire [15:0] pc_rel;
   wire [15:0] pc_brel;
   wire [16:0] wsum;
   wire [16:0] wdif;
   wire skip;
   wire taken;

   // Flag bit test shared by all conditional branches
   function branch_cond;
      input [5:0] op;
      input [7:0] f;
      input [2:0] s;
      begin
         case (op)
            `CAB_OP_BFH: branch_cond = f[s];
            `CAB_OP_BFL: branch_cond = ~f[s];
            `CAB_OP_BEQ: branch_cond = f[`CAB_FZ];
            `CAB_OP_BNE: branch_cond = ~f[`CAB_FZ];
            `CAB_OP_BCH: branch_cond = f[`CAB_FC];
            `CAB_OP_BCL: branch_cond = ~f[`CAB_FC];
            `CAB_OP_BUGE: branch_cond = ~f[`CAB_FC];
            `CAB_OP_BULT: branch_cond = f[`CAB_FC];
            `CAB_OP_BNEG: branch_cond = f[`CAB_FN];
            `CAB_OP_BNNEG: branch_cond = ~f[`CAB_FN];
            `CAB_OP_BSGE: branch_cond = ~(f[`CAB_FN] ^ f[`CAB_FV]);
            `CAB_OP_BSLT: branch_cond = f[`CAB_FN] ^ f[`CAB_FV];
            `CAB_OP_BHH: branch_cond = f[`CAB_FH];
            `CAB_OP_BHL: branch_cond = ~f[`CAB_FH];
            default: branch_cond = 1'b0;
         endcase
      end
   endfunction

   // Skip condition of compare and bit test skips
   function skip_cond;
      input [5:0] op;
      input [7:0] rd;
      input [7:0] rr;
      input [2:0] s;
      input io;
      begin
         case (op)
            `CAB_OP_CESKIP: skip_cond = (rd == rr);
            `CAB_OP_SRBL: skip_cond = ~rr[s];
            `CAB_OP_SRBH: skip_cond = rr[s];
            `CAB_OP_SIBL: skip_cond = ~io;
            `CAB_OP_SIBH: skip_cond = io;
            default: skip_cond = 1'b0;
         endcase
      end
   endfunction

   // Reset release through two flip-flops
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   cab_alu8 u_alu (
      .a_in(alu_a),
      .b_in(alu_b),
      .cin_in(alu_cin),
      .mode_in(alu_mode),
      .res_out(alu_res),
      .c_out(alu_c),
      .h_out(alu_h),
      .v_out(alu_v)
   );

   cab_mul u_mul (
      .a_in(rd_val_in),
      .b_in(rr_val_in),
      .a_signed_in(mul_as),
      .b_signed_in(mul_bs),
      .frac_in(mul_frac),
      .prod_out(mul_prod),
      .carry_out(mul_c)
   );

   // Displacements sign extended to the counter width
   assign pc_inc = pc_in + 16'h0001;
   assign pc_rel = pc_in + {{4{disp_in[11]}}, disp_in} + 16'h0001;
   assign pc_brel = pc_in + {{9{disp_in[6]}}, disp_in[6:0]} + 16'h0001;
   assign wsum = {1'b0, word_in} + {9'h000, imm_in};
   assign wdif = {1'b0, word_in} - {9'h000, imm_in};
   assign skip = skip_cond(op_in, rd_val_in, rr_val_in, bit_sel_in, io_bit_in);
   assign taken = branch_cond(op_in, flags_out, bit_sel_in);

   // Operand steering for the eight-bit unit
   always @* begin
      alu_a = rd_val_in;
      alu_b = rr_val_in;
      alu_cin = 1'b0;
      alu_mode = `CAB_ALU_ADD;
      case (op_in)
         `CAB_OP_ADC: alu_cin = flags_out[`CAB_FC];
         `CAB_OP_SUB, `CAB_OP_DFO: alu_mode = `CAB_ALU_SUB;
         `CAB_OP_DIFI, `CAB_OP_DFI: begin
            alu_mode = `CAB_ALU_SUB;
            alu_b = imm_in;
         end
         `CAB_OP_DIFB, `CAB_OP_DFC: begin
            alu_mode = `CAB_ALU_SUB;
            alu_cin = flags_out[`CAB_FC];
         end
         `CAB_OP_DIFIB: begin
            alu_mode = `CAB_ALU_SUB;
            alu_b = imm_in;
            alu_cin = flags_out[`CAB_FC];
         end
         `CAB_OP_AND: alu_mode = `CAB_ALU_AND;
         `CAB_OP_CONJI: begin
            alu_mode = `CAB_ALU_AND;
            alu_b = imm_in;
         end
         `CAB_OP_OR: alu_mode = `CAB_ALU_OR;
         `CAB_OP_UNI, `CAB_OP_SETM: begin
            alu_mode = `CAB_ALU_OR;
            alu_b = imm_in;
         end
         `CAB_OP_XUNI: alu_mode = `CAB_ALU_XOR;
         `CAB_OP_CLRM: begin
            alu_mode = `CAB_ALU_AND;
            alu_b = 8'hff - imm_in;
         end
         `CAB_OP_INV: begin
            alu_mode = `CAB_ALU_XOR;
            alu_b = 8'hff;
         end
         `CAB_OP_AINV: begin
            alu_mode = `CAB_ALU_SUB;
            alu_a = 8'h00;
            alu_b = rd_val_in;
         end
         `CAB_OP_INC: alu_b = 8'h01;
         `CAB_OP_DEC: begin
            alu_mode = `CAB_ALU_SUB;
            alu_b = 8'h01;
         end
         `CAB_OP_PROBE: begin
            alu_mode = `CAB_ALU_AND;
            alu_b = rd_val_in;
         end
         `CAB_OP_ZERO: begin
            alu_mode = `CAB_ALU_XOR;
            alu_b = rd_val_in;
         end
         default: alu_mode = `CAB_ALU_ADD;
      endcase
   end

   // Result, flags, counter and timing of each operation
   always @* begin
      next_res = alu_res;
      next_word = wsum[15:0];
      next_pc = pc_inc;
      next_push = pc_inc;
      next_cyc = `CAB_CYC_1;
      next_rd_we = 1'b0;
      next_word_we = 1'b0;
      next_prod_we = 1'b0;
      next_push_we = 1'b0;
      next_mask = 8'h00;
      next_calc = {2'b00, alu_h, 1'b0, alu_v, alu_res[7], alu_res == 8'h00, alu_c};
      mul_as = 1'b0;
      mul_bs = 1'b0;
      mul_frac = 1'b0;
      case (op_in)
         `CAB_OP_ADD, `CAB_OP_ADC, `CAB_OP_SUB, `CAB_OP_DIFI: begin
            next_rd_we = 1'b1;
            next_mask = `CAB_M_ARITH;
         end
         `CAB_OP_DIFB, `CAB_OP_DIFIB: begin
            next_rd_we = 1'b1;
            next_mask = `CAB_M_ARITH;
            next_calc[`CAB_FZ] = (alu_res == 8'h00) & flags_out[`CAB_FZ];
         end
         `CAB_OP_DFO, `CAB_OP_DFI: next_mask = `CAB_M_ARITH;
         `CAB_OP_DFC: begin
            next_mask = `CAB_M_ARITH;
            next_calc[`CAB_FZ] = (alu_res == 8'h00) & flags_out[`CAB_FZ];
         end
         `CAB_OP_WSUM, `CAB_OP_WDIF: begin
            next_word = (op_in == `CAB_OP_WSUM) ? wsum[15:0] : wdif[15:0];
            next_word_we = 1'b1;
            next_cyc = `CAB_CYC_2;
            next_mask = `CAB_M_WORD;
            next_calc[`CAB_FC] = (op_in == `CAB_OP_WSUM) ? wsum[16] : wdif[16];
            next_calc[`CAB_FZ] = (next_word == 16'h0000);
            next_calc[`CAB_FN] = next_word[15];
            next_calc[`CAB_FV] = (op_in == `CAB_OP_WSUM) ? (~word_in[15] & next_word[15]) :
                                 (word_in[15] & ~next_word[15]);
            next_calc[`CAB_FS] = next_calc[`CAB_FN] ^ next_calc[`CAB_FV];
         end
         `CAB_OP_AND, `CAB_OP_CONJI, `CAB_OP_OR, `CAB_OP_UNI, `CAB_OP_XUNI: begin
            next_rd_we = 1'b1;
            next_mask = `CAB_M_LOGIC;
         end
         `CAB_OP_SETM, `CAB_OP_CLRM, `CAB_OP_INC, `CAB_OP_DEC, `CAB_OP_ZERO: begin
            next_rd_we = 1'b1;
            next_mask = `CAB_M_LOGIC;
         end
         `CAB_OP_PROBE: next_mask = `CAB_M_LOGIC;
         `CAB_OP_INV: begin
            next_rd_we = 1'b1;
            next_mask = `CAB_M_INV;
            next_calc[`CAB_FC] = 1'b1;
            next_calc[`CAB_FV] = 1'b0;
         end
         `CAB_OP_AINV: begin
            next_rd_we = 1'b1;
            next_mask = `CAB_M_ARITH;
         end
         `CAB_OP_ONES: begin
            next_res = 8'hff;
            next_rd_we = 1'b1;
         end
         `CAB_OP_UPROD, `CAB_OP_SPROD, `CAB_OP_MPROD, `CAB_OP_FUPROD, `CAB_OP_FSPROD, `CAB_OP_FMPROD: begin
            mul_as = (op_in == `CAB_OP_SPROD) || (op_in == `CAB_OP_MPROD) ||
                     (op_in == `CAB_OP_FSPROD) || (op_in == `CAB_OP_FMPROD);
            mul_bs = (op_in == `CAB_OP_SPROD) || (op_in == `CAB_OP_FSPROD);
            mul_frac = (op_in == `CAB_OP_FUPROD) || (op_in == `CAB_OP_FSPROD) ||
                       (op_in == `CAB_OP_FMPROD);
            next_prod_we = 1'b1;
            next_cyc = `CAB_CYC_2;
            next_mask = `CAB_M_MUL;
            next_calc[`CAB_FC] = mul_c;
            next_calc[`CAB_FZ] = (mul_prod == 16'h0000);
         end
         `CAB_OP_RGOTO: begin
            next_pc = pc_rel;
            next_cyc = `CAB_CYC_2;
         end
         `CAB_OP_PGOTO: begin
            next_pc = z_ptr_in;
            next_cyc = `CAB_CYC_2;
         end
         `CAB_OP_AGOTO: begin
            next_pc = target_in;
            next_cyc = `CAB_CYC_3;
         end
         `CAB_OP_RINVOKE, `CAB_OP_PINVOKE: begin
            next_pc = (op_in == `CAB_OP_RINVOKE) ? pc_rel : z_ptr_in;
            next_push_we = 1'b1;
            next_cyc = `CAB_CYC_3;
         end
         `CAB_OP_AINVOKE: begin
            next_pc = target_in;
            next_push = pc_in + 16'h0002;
            next_push_we = 1'b1;
            next_cyc = `CAB_CYC_4;
         end
         `CAB_OP_REXIT: begin
            next_pc = stack_pc_in;
            next_cyc = `CAB_CYC_4;
         end
         `CAB_OP_IEXIT: begin
            next_pc = stack_pc_in;
            next_cyc = `CAB_CYC_4;
            next_mask = `CAB_M_IRQ;
            next_calc[`CAB_FI] = 1'b1;
         end
         `CAB_OP_CESKIP, `CAB_OP_SRBL, `CAB_OP_SRBH, `CAB_OP_SIBL, `CAB_OP_SIBH: begin
            if (skip) begin
               next_pc = pc_in + (next_two_word_in ? 16'h0003 : 16'h0002);
               next_cyc = next_two_word_in ? `CAB_CYC_3 : `CAB_CYC_2;
            end
         end
         `CAB_OP_BFH, `CAB_OP_BFL, `CAB_OP_BEQ, `CAB_OP_BNE, `CAB_OP_BCH, `CAB_OP_BCL, `CAB_OP_BUGE,
         `CAB_OP_BULT, `CAB_OP_BNEG, `CAB_OP_BNNEG, `CAB_OP_BSGE, `CAB_OP_BSLT, `CAB_OP_BHH, `CAB_OP_BHL: begin
            if (taken) begin
               next_pc = pc_brel;
               next_cyc = `CAB_CYC_2;
            end
         end
         default: next_mask = 8'h00;
      endcase
   end

   // Only masked flags take the computed value
   assign next_flags = (flags_out & ~next_mask) | (next_calc & next_mask);
   assign take = start_in & ~busy_out;
   assign fire = (take && (next_cyc == `CAB_CYC_1)) || (busy_out && (cnt == 3'h1));
   assign fire_we = busy_out ? pend_we : {next_push_we, next_prod_we, next_word_we, next_rd_we};
   assign fire_flags = busy_out ? pend_flags : next_flags;

   always @(posedge sys_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         busy_out <= 1'b0;
         done_out <= 1'b0;
         cnt <= 3'h0;
         rd_we_out <= 1'b0;
         word_we_out <= 1'b0;
         prod_we_out <= 1'b0;
         pc_we_out <= 1'b0;
         push_we_out <= 1'b0;
         result_out <= 8'h00;
         word_out <= 16'h0000;
         product_out <= 16'h0000;
         pc_out <= 16'h0000;
         push_addr_out <= 16'h0000;
         flags_out <= `CAB_FLAGS_RST;
         pend_flags <= `CAB_FLAGS_RST;
         pend_we <= 4'h0;
      end else begin
         done_out <= fire;
         pc_we_out <= fire;
         rd_we_out <= fire & fire_we[0];
         word_we_out <= fire & fire_we[1];
         prod_we_out <= fire & fire_we[2];
         push_we_out <= fire & fire_we[3];
         if (take) begin
            result_out <= next_res;
            word_out <= next_word;
            product_out <= mul_prod;
            pc_out <= next_pc;
            push_addr_out <= next_push;
            pend_flags <= next_flags;
            pend_we <= {next_push_we, next_prod_we, next_word_we, next_rd_we};
            cnt <= next_cyc - 3'h1;
            busy_out <= (next_cyc != `CAB_CYC_1);
         end else if (busy_out) begin
            cnt <= cnt - 3'h1;
            busy_out <= (cnt != 3'h1);
         end
         // Instruction update wins over a core flag load
         if (fire) begin
            flags_out <= fire_flags;
         end else if (flags_we_in) begin
            flags_out <= flags_wr_in;
         end
      end
   end
endmodule // cab_exec
`default_nettype wire

/* File: tb/cab_exec_monitor.sv */
// Concurrent checks on the execution unit ports
`timescale 1ns/1ps
`default_nettype none
`include "cab_defs.vh"
module cab_exec_monitor (
   // Request side
   input wire sys_clk_in, input wire resetn_in, input wire start_in, input wire [5:0] op_in,
   input wire [7:0] rd_val_in, input wire [7:0] rr_val_in, input wire [15:0] pc_in,
   input wire [11:0] disp_in, input wire [15:0] target_in, input wire [15:0] stack_pc_in,
   // Result side
   input wire busy_out, input wire done_out, input wire rd_we_out, input wire [7:0] result_out,
   input wire prod_we_out, input wire [15:0] product_out, input wire [7:0] flags_out,
   input wire [15:0] pc_out, input wire push_we_out, input wire [15:0] push_addr_out
);
   wire tk = start_in && !busy_out;
   wire [15:0] rj = pc_in + {{4{disp_in[11]}}, disp_in} + 16'h1;
   wire [15:0] bj = pc_in + {{9{disp_in[6]}}, disp_in[6:0]} + 16'h1;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   a_add_result: assert property (tk && op_in == `CAB_OP_ADD |=> done_out && rd_we_out &&
      result_out == $past(rd_val_in) + $past(rr_val_in)) else $error("add result wrong");
   a_mul_product: assert property (tk && op_in == `CAB_OP_UPROD |=> !done_out ##1 done_out &&
      prod_we_out && product_out == $past(rd_val_in, 2) * $past(rr_val_in, 2)) else $error("product wrong");
   a_rgoto_target: assert property (tk && op_in == `CAB_OP_RGOTO |=> !done_out ##1 done_out &&
      pc_out == $past(rj, 2)) else $error("relative goto wrong");
   a_agoto_cycles: assert property (tk && op_in == `CAB_OP_AGOTO |=> !done_out [*2] ##1 done_out &&
      pc_out == $past(target_in, 3)) else $error("absolute goto wrong");
   a_invoke_push: assert property (tk && op_in == `CAB_OP_AINVOKE |=> !done_out [*3] ##1 push_we_out &&
      push_addr_out == $past(pc_in, 4) + 16'h2) else $error("invoke push wrong");
   a_exit_irq: assert property (tk && op_in == `CAB_OP_IEXIT |=> !done_out [*3] ##1 done_out &&
      flags_out[7] && pc_out == $past(stack_pc_in, 4)) else $error("irq exit wrong");
   a_ones_flags: assert property (tk && op_in == `CAB_OP_ONES |=> result_out == 8'hff &&
      flags_out == $past(flags_out)) else $error("all ones wrong");
   a_beq_taken: assert property (tk && op_in == `CAB_OP_BEQ && flags_out[1] |=> !done_out ##1 done_out &&
      pc_out == $past(bj, 2)) else $error("equal branch wrong");
   a_bsge_fall: assert property (tk && op_in == `CAB_OP_BSGE && (flags_out[2] ^ flags_out[3]) |=>
      done_out && pc_out == $past(pc_in) + 16'h1) else $error("signed branch wrong");
endmodule // cab_exec_monitor
`default_nettype wire

/* File: tb/cab_stack_model.sv */
// Stack memory model that takes return addresses
`timescale 1ns/1ps
`default_nettype none
module cab_stack_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Push and top of stack
   input wire logic push_in,
   input wire logic [15:0] addr_in,
   output logic [15:0] top_out
);
   logic [15:0] mem [0:7];
   logic [2:0] sp;
   initial for (int i = 0; i < 8; i++) mem[i] = 16'h8000 | i[15:0];
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) sp <= 3'h0;
      else if (push_in) begin
         mem[sp + 3'h1] <= addr_in;
         sp <= sp + 3'h1;
      end
   end
   assign top_out = mem[sp];
endmodule // cab_stack_model
`default_nettype wire

/* File: tb/cab_exec_tb.sv */
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "cab_defs.vh"
module cab_exec_tb;
   typedef struct {logic [7:0] r, fl; logic [15:0] q, p; logic [3:0] we;} note_t;
   note_t nq[$];
   note_t e, g;
   logic clk = 0, rn = 0, st = 0, fwe = 0, io = 0, tw = 0, cin;
   logic [5:0] op = 0;
   logic [7:0] a = 0, b = 0, k = 0, f = 0, fwr = 0;
   logic [15:0] w = 0, pc = 0, tg = 0, z = 0;
   logic [11:0] d = 0;
   logic [2:0] bs = 0;
   logic [8:0] s;
   logic [5:0] ops [0:23] = '{`CAB_OP_ADD, `CAB_OP_ADC, `CAB_OP_SUB, `CAB_OP_DIFB, `CAB_OP_DFO, `CAB_OP_AND,
      `CAB_OP_AINV, `CAB_OP_ONES, `CAB_OP_UPROD, `CAB_OP_FUPROD, `CAB_OP_RGOTO, `CAB_OP_AGOTO, `CAB_OP_AINVOKE,
      `CAB_OP_IEXIT, `CAB_OP_CESKIP, `CAB_OP_SIBH, `CAB_OP_BEQ, `CAB_OP_BSGE, `CAB_OP_BFH, `CAB_OP_SETM,
      `CAB_OP_CLRM, `CAB_OP_SRBL, `CAB_OP_WSUM, 6'h3f};
   wire [15:0] sp, wo, po, pco, pa;
   wire [7:0] ro, fo;
   wire by, dn, rwe, wwe, pwe, pcw, psh;
   int errors = 0, n_checks = 0, seed = 32'h346f36c4, n;
   cab_exec dut (.sys_clk_in(clk), .resetn_in(rn), .start_in(st), .op_in(op), .rd_val_in(a), .rr_val_in(b),
      .imm_in(k), .word_in(w), .bit_sel_in(bs), .io_bit_in(io), .next_two_word_in(tw), .pc_in(pc),
      .disp_in(d), .target_in(tg), .z_ptr_in(z), .stack_pc_in(sp), .flags_we_in(fwe), .flags_wr_in(fwr),
      .busy_out(by), .done_out(dn), .rd_we_out(rwe), .result_out(ro), .word_we_out(wwe), .word_out(wo),
      .prod_we_out(pwe), .product_out(po), .flags_out(fo), .pc_we_out(pcw), .pc_out(pco),
      .push_we_out(psh), .push_addr_out(pa));
   cab_stack_model u_stk (.clk_in(clk), .resetn_in(rn), .push_in(psh), .addr_in(pa), .top_out(sp));
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task ar(input [8:0] v9, input hh, vv, wr, zk);
      e.fl[0] = v9[8];
      e.fl[1] = v9[7:0] == 0 && zk;
      e.fl[2] = v9[7];
      e.fl[3] = vv;
      e.fl[5] = hh;
      e.r = v9[7:0];
      e.we[3] = wr;
   endtask
   task run(input [5:0] o);
      #1 op = o;
      fwe = 0;
      st = 1;
      {a, b, k, w, pc, tg, z, d, bs, io, tw} = 105'({$random(seed), $random(seed), $random(seed), $random(seed)});
      if (io) b = a;
      e = '{r: 0, fl: f, q: 0, p: pc + 1, we: 0};
      n = 1;
      cin = f[0] && (o == `CAB_OP_ADC || o == `CAB_OP_DIFB);
      case (o)
         `CAB_OP_ADD, `CAB_OP_ADC: begin
            s = a + b + cin;
            ar(s, a[3:0] + b[3:0] + cin > 15, a[7] == b[7] && s[7] != a[7], 1, 1);
         end
         `CAB_OP_SUB, `CAB_OP_DIFB, `CAB_OP_DFO: begin
            s = {1'b0, a} - b - cin;
            ar(s, {1'b0, a[3:0]} < {1'b0, b[3:0]} + cin, a[7] != b[7] && s[7] != a[7],
               o != `CAB_OP_DFO, o != `CAB_OP_DIFB || f[1]);
         end
         `CAB_OP_AND: ar({f[0], a & b}, f[5], 0, 1, 1);
         `CAB_OP_SETM: ar({f[0], a | k}, f[5], 0, 1, 1);
         `CAB_OP_CLRM: ar({f[0], a & ~k}, f[5], 0, 1, 1);
         `CAB_OP_AINV: ar({a != 0, 8'h0 - a}, a[3:0] != 0, a == 8'h80, 1, 1);
         `CAB_OP_ONES: begin
            e.r = 8'hff;
            e.we[3] = 1;
         end
         `CAB_OP_UPROD, `CAB_OP_FUPROD: begin
            e.q = a * b;
            e.fl[0] = e.q[15];
            if (o == `CAB_OP_FUPROD) e.q = e.q << 1;
            e.fl[1] = e.q == 0;
            e.we[1] = 1;
            n = 2;
         end
         `CAB_OP_RGOTO: begin
            e.p = pc + {{4{d[11]}}, d} + 1;
            n = 2;
         end
         `CAB_OP_WSUM: begin
            {e.fl[0], e.q} = w + k;
            e.fl[4:1] = {e.q[15] & w[15], e.q[15] & !w[15], e.q[15], e.q == 0};
            e.we[2] = 1;
            n = 2;
         end
         `CAB_OP_AGOTO, `CAB_OP_AINVOKE: begin
            e.p = tg;
            e.q = pc + 2;
            e.we[0] = o == `CAB_OP_AINVOKE;
            n = o == `CAB_OP_AGOTO ? 3 : 4;
         end
         `CAB_OP_IEXIT: begin
            e.p = sp;
            e.fl[7] = 1;
            n = 4;
         end
         `CAB_OP_CESKIP, `CAB_OP_SIBH, `CAB_OP_SRBL:
            if (o == `CAB_OP_SIBH ? io : o == `CAB_OP_SRBL ? !b[bs] : a == b) begin
               e.p = pc + 2 + tw;
               n = 2 + tw;
            end
         `CAB_OP_BEQ, `CAB_OP_BSGE, `CAB_OP_BFH:
            if (o == `CAB_OP_BEQ ? f[1] : o == `CAB_OP_BFH ? f[bs] : !(f[2] ^ f[3])) begin
               e.p = pc + {{9{d[6]}}, d[6:0]} + 1;
               n = 2;
            end
         default: ;
      endcase
      f = e.fl;
      nq.push_back(e);
      repeat (n) @(posedge clk);
   endtask
   always @(negedge clk) if (dn === 1'b1) begin
      if (nq.size() == 0) chk("note", 16'h1, 16'h0);
      else begin
         g = nq.pop_front();
         chk("pc", pco, g.p);
         chk("flags", fo, g.fl);
         chk("writes", {rwe, wwe, pwe, psh, pcw, by}, {g.we, 1'b1, 1'b0});
         if (g.we[3]) chk("result", ro, g.r);
         if (g.we[1]) chk("product", po, g.q);
         if (g.we[0]) chk("push", pa, g.q);
         if (g.we[2]) chk("word", wo, g.q);
      end
   end
   task print_verdict;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial forever #5 clk = ~clk;
   initial begin
      #100000;
      errors++;
      print_verdict;
   end
   initial begin
      repeat (2) @(posedge clk);
      #1 rn = 1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 400; i++) begin
         if (i % 8 == 0) begin
            #1 st = 0;
            fwe = 1;
            fwr = $random(seed);
            f = fwr;
            @(posedge clk);
         end
         run(ops[{$random(seed)} % 23]);
      end
      #1 st = 0;
      repeat (6) @(posedge clk);
      chk("left", 16'(nq.size()), 16'h0);
      print_verdict;
   end
endmodule // cab_exec_tb
bind cab_exec cab_exec_monitor u_mon (.sys_clk_in, .resetn_in, .start_in, .op_in, .rd_val_in, .rr_val_in,
   .pc_in, .disp_in, .target_in, .stack_pc_in, .busy_out, .done_out, .rd_we_out, .result_out, .prod_we_out,
   .product_out, .flags_out, .pc_out, .push_we_out, .push_addr_out);
`default_nettype wire
